//--- verilog/frt_scale.sv
// Purpose: Meter factor, total and rate scaling, timebase, rate filter, display select.
// Assumes: PULSE_A_I is a one-cycle strobe per conditioned input pulse.
// Notes: Divisors are integers scaled by 10000; outputs have 16 fraction bits.
`timescale 1ns/1ns
`default_nettype none
module frt_scale #(
  parameter logic [frt_pkg::UPD_W-1:0] UPD_CYC = frt_pkg::UPD_CYC_DEF,
  parameter logic [frt_pkg::PER_W-1:0] ZERO_CYC = frt_pkg::ZERO_CYC_DEF
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  // Pulse input
  input wire logic PULSE_A_I,
  input wire logic TOTAL_CLR_I,
  // Scaling configuration
  input wire logic [frt_pkg::FAC_W-1:0] INPUT_A_PULSE_DIVISOR_I,
  input wire logic [frt_pkg::FAC_W-1:0] TOTAL_SCALE_DIVISOR_I,
  input wire logic [frt_pkg::FAC_W-1:0] RATE_SCALE_DIVISOR_I,
  input wire logic [1:0] RATE_TIMEBASE_SELECT_I,
  input wire logic [7:0] RATE_SMOOTHING_SETTING_I,
  // Segment table
  input wire logic LIN_EN_I,
  input wire logic [4:0] LIN_COUNT_I,
  input wire logic LIN_WE_I,
  input wire logic [3:0] LIN_ADDR_I,
  input wire logic [frt_pkg::PER_W-1:0] LIN_PERIOD_I,
  input wire logic [frt_pkg::FAC_W-1:0] LIN_FACTOR_I,
  // Display configuration
  input wire logic UPPER_SHOWS_RATE_I,
  input wire logic [2:0] UPPER_DECIMAL_POINT_POSITION_I,
  input wire logic [2:0] LOWER_DECIMAL_POINT_POSITION_I,
  input wire logic [1:0] MENU_MODE_I,
  // Results
  output logic [frt_pkg::VAL_W-1:0] TOTAL_O,
  output logic [frt_pkg::VAL_W-1:0] RATE_O,
  output logic RATE_ZERO_O,
  output logic CLIP_CLEAR_O,
  // Display drive
  output logic [frt_pkg::VAL_W-1:0] UPPER_VALUE_O,
  output logic [frt_pkg::VAL_W-1:0] LOWER_VALUE_O,
  output logic [2:0] UPPER_DP_O,
  output logic [2:0] LOWER_DP_O,
  output logic RATE_ANN_O,
  output logic TOTAL_ANN_O
);
  localparam int VW = frt_pkg::VAL_W;
  localparam int DW = frt_pkg::DIV_W;
  localparam int CFG_W = 3 * frt_pkg::FAC_W + 5;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_LIN = 5'h02,
    ST_TOT = 5'h04,
    ST_RATE = 5'h08,
    ST_FILT = 5'h10
  } frt_state_t;

  typedef struct packed {
    frt_state_t state;
    logic [frt_pkg::UPD_W-1:0] upd_cnt;
    logic [frt_pkg::CNT_W-1:0] count;
    logic [frt_pkg::PER_W-1:0] elapsed;
    logic [frt_pkg::PER_W-1:0] period;
    logic [4:0] lin_idx;
    logic [frt_pkg::FAC_W-1:0] mf;
    logic [DW:0] rem;
    logic [DW-1:0] quo;
    logic [DW-1:0] den;
    logic [6:0] bit_cnt;
    logic stale;
    logic [VW-1:0] total;
    logic [VW-1:0] rate_raw;
    logic [VW-1:0] rate_filt;
    logic [VW-1:0] upper_val;
    logic [VW-1:0] lower_val;
    logic [2:0] upper_dp;
    logic [2:0] lower_dp;
    logic rate_ann;
    logic total_ann;
    logic clip_clear;
    logic [CFG_W-1:0] cfg_prev;
  } frt_regs_t;

  frt_regs_t s_q;
  frt_regs_t s_d;

  logic [frt_pkg::LIN_DW-1:0] lin_rdata;
  logic tick;
  logic [DW:0] tr;
  logic [DW-1:0] res;
  logic [VW-1:0] diff;
  logic [65:0] step;
  logic ovr;
  logic [3:0] tau_d;
  logic [3:0] dev_d;
  logic [16:0] alpha;
  logic [2:0] rate_dp;
  logic [CFG_W-1:0] cfg_now;

  // ----------------------------------------------------------------
  // Segment table
  // ----------------------------------------------------------------
  frt_lin_mem #(
    .DEPTH(frt_pkg::LIN_DEPTH),
    .DW(frt_pkg::LIN_DW)
  ) u_lin_mem (
    .clk_i(CORE_CLK_I),
    .rstn_i(RSTN_I),
    .we_i(LIN_WE_I),
    .waddr_i(LIN_ADDR_I),
    .wdata_i({LIN_PERIOD_I, LIN_FACTOR_I}),
    .raddr_i(s_q.lin_idx[3:0]),
    .rdata_o(lin_rdata)
  );

  function automatic logic [VW-1:0] frt_sat(input logic [DW-1:0] q, input logic [DW-1:0] d);
    if (d == '0)
    begin
      return '0;
    end
    return (|q[DW-1:VW]) ? '1 : q[VW-1:0];
  endfunction : frt_sat

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.clip_clear = 1'b0;
    tr = '0;
    res = '0;
    step = '0;
    tau_d = frt_pkg::frt_digit(RATE_SMOOTHING_SETTING_I[7:4]);
    dev_d = frt_pkg::frt_digit(RATE_SMOOTHING_SETTING_I[3:0]);
    alpha = frt_pkg::frt_alpha(tau_d);
    diff = (s_q.rate_raw > s_q.rate_filt) ? s_q.rate_raw - s_q.rate_filt :
      s_q.rate_filt - s_q.rate_raw;
    ovr = (dev_d != 4'h0) && (64'(diff) * 64'h64 >
      64'(s_q.rate_filt) * 64'(frt_pkg::DEV_PCT[dev_d]));
    rate_dp = UPPER_SHOWS_RATE_I ? UPPER_DECIMAL_POINT_POSITION_I :
      LOWER_DECIMAL_POINT_POSITION_I;
    cfg_now = {INPUT_A_PULSE_DIVISOR_I, TOTAL_SCALE_DIVISOR_I, RATE_SCALE_DIVISOR_I,
      RATE_TIMEBASE_SELECT_I, rate_dp};
    s_d.cfg_prev = cfg_now;
    if (cfg_now != s_q.cfg_prev)
    begin
      s_d.clip_clear = 1'b1;
    end
    tick = (s_q.upd_cnt == UPD_CYC - 1'b1);
    s_d.upd_cnt = tick ? '0 : s_q.upd_cnt + 1'b1;
    if (TOTAL_CLR_I)
    begin
      s_d.count = '0;
    end
    else if (PULSE_A_I)
    begin
      s_d.count = s_q.count + 1'b1;
    end
    if (PULSE_A_I)
    begin
      s_d.period = s_q.elapsed + 1'b1;
      s_d.elapsed = '0;
    end
    else if (s_q.elapsed < ZERO_CYC)
    begin
      s_d.elapsed = s_q.elapsed + 1'b1;
    end
    s_d.stale = (s_q.period == '0) || (s_q.elapsed >= ZERO_CYC);
    unique case (s_q.state)
      ST_IDLE:
      begin
        if (tick && LIN_EN_I)
        begin
          s_d.lin_idx = '0;
          s_d.state = ST_LIN;
        end
        else if (tick)
        begin
          s_d.mf = INPUT_A_PULSE_DIVISOR_I;
          s_d.state = ST_TOT;
        end
      end
      ST_LIN:
      begin
        s_d.lin_idx = s_q.lin_idx + 5'h01;
        if ((s_q.lin_idx == 5'h01) || ((s_q.lin_idx != 5'h00) &&
          (s_q.lin_idx <= LIN_COUNT_I) &&
          (s_q.period <= lin_rdata[frt_pkg::LIN_DW-1:frt_pkg::FAC_W])))
        begin
          s_d.mf = lin_rdata[frt_pkg::FAC_W-1:0];
        end
        if (s_q.lin_idx == 5'(frt_pkg::LIN_DEPTH))
        begin
          s_d.state = ST_TOT;
        end
      end
      ST_TOT, ST_RATE:
      begin
        tr = {s_q.rem[DW-1:0], s_q.quo[DW-1]};
        if (tr >= {1'b0, s_q.den})
        begin
          s_d.rem = tr - {1'b0, s_q.den};
          s_d.quo = {s_q.quo[DW-2:0], 1'b1};
        end
        else
        begin
          s_d.rem = tr;
          s_d.quo = {s_q.quo[DW-2:0], 1'b0};
        end
        s_d.bit_cnt = s_q.bit_cnt + 7'h01;
        if (s_q.bit_cnt == 7'(DW - 1))
        begin
          res = s_d.quo;
          if (s_q.state == ST_TOT)
          begin
            s_d.total = frt_sat(res, s_q.den);
            s_d.state = ST_RATE;
          end
          else
          begin
            s_d.rate_raw = s_q.stale ? '0 : frt_sat(res, s_q.den);
            s_d.state = ST_FILT;
          end
        end
      end
      ST_FILT:
      begin
        step = (66'(diff) * 66'(alpha)) >> 16;
        if (ovr || (alpha == frt_pkg::ALPHA_ONE) || (s_q.rate_raw == '0))
        begin
          s_d.rate_filt = s_q.rate_raw;
        end
        else if (s_q.rate_raw > s_q.rate_filt)
        begin
          s_d.rate_filt = s_q.rate_filt + step[VW-1:0];
        end
        else
        begin
          s_d.rate_filt = s_q.rate_filt - step[VW-1:0];
        end
        s_d.state = ST_IDLE;
      end
    endcase
    // Loading of the divider for the total and the rate jobs.
    if ((s_q.state != ST_TOT) && (s_d.state == ST_TOT))
    begin
      s_d.rem = '0;
      s_d.bit_cnt = '0;
      s_d.quo = (DW'(s_q.count) * frt_pkg::DEC_SCALE) << frt_pkg::FRAC_BITS;
      s_d.den = DW'(s_d.mf) * DW'(TOTAL_SCALE_DIVISOR_I);
    end
    if ((s_q.state == ST_TOT) && (s_d.state == ST_RATE))
    begin
      s_d.rem = '0;
      s_d.bit_cnt = '0;
      s_d.quo = (DW'(frt_pkg::CLK_HZ) * DW'(frt_pkg::frt_tb(RATE_TIMEBASE_SELECT_I)) *
        frt_pkg::DEC_SCALE) << frt_pkg::FRAC_BITS;
      s_d.den = DW'(s_q.period) * DW'(s_q.mf) * DW'(RATE_SCALE_DIVISOR_I);
    end
    // Display selection follows the menu mode.
    s_d.upper_val = UPPER_SHOWS_RATE_I ? s_q.rate_filt : s_q.total;
    s_d.lower_val = UPPER_SHOWS_RATE_I ? s_q.total : s_q.rate_filt;
    s_d.upper_dp = frt_pkg::frt_dp(UPPER_DECIMAL_POINT_POSITION_I, frt_pkg::UP_DP_MAX);
    s_d.lower_dp = frt_pkg::frt_dp(LOWER_DECIMAL_POINT_POSITION_I, frt_pkg::LO_DP_MAX);
    s_d.rate_ann = UPPER_SHOWS_RATE_I;
    s_d.total_ann = !UPPER_SHOWS_RATE_I;
    if (MENU_MODE_I == frt_pkg::MENU_DP_LO)
    begin
      s_d.upper_val = UPPER_SHOWS_RATE_I ? s_q.total : s_q.rate_filt;
      s_d.upper_dp = frt_pkg::frt_dp(LOWER_DECIMAL_POINT_POSITION_I, frt_pkg::LO_DP_MAX);
      s_d.rate_ann = !UPPER_SHOWS_RATE_I;
      s_d.total_ann = UPPER_SHOWS_RATE_I;
    end
    if (MENU_MODE_I == frt_pkg::MENU_FILT)
    begin
      s_d.lower_val = s_q.rate_filt;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      s_q <= '{state: ST_IDLE, default: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign TOTAL_O = s_q.total;
  assign RATE_O = s_q.rate_filt;
  assign RATE_ZERO_O = s_q.stale;
  assign CLIP_CLEAR_O = s_q.clip_clear;
  assign UPPER_VALUE_O = s_q.upper_val;
  assign LOWER_VALUE_O = s_q.lower_val;
  assign UPPER_DP_O = s_q.upper_dp;
  assign LOWER_DP_O = s_q.lower_dp;
  assign RATE_ANN_O = s_q.rate_ann;
  assign TOTAL_ANN_O = s_q.total_ann;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  dp_upper_a: assert property ((MENU_MODE_I == frt_pkg::MENU_DP_UP) |=>
    (RATE_ANN_O == $past(UPPER_SHOWS_RATE_I)) && (TOTAL_ANN_O != RATE_ANN_O))
    else $error("Annunciator does not match upper variable.");
  dp_lower_a: assert property ((MENU_MODE_I == frt_pkg::MENU_DP_LO) |=>
    (RATE_ANN_O != $past(UPPER_SHOWS_RATE_I)) && (UPPER_DP_O <= frt_pkg::LO_DP_MAX))
    else $error("Lower variable not moved to upper display.");
  dp_range_a: assert property ((UPPER_DP_O <= frt_pkg::UP_DP_MAX) &&
    (LOWER_DP_O <= frt_pkg::LO_DP_MAX))
    else $error("Decimal point beyond display width.");
  filt_edit_a: assert property ((MENU_MODE_I == frt_pkg::MENU_FILT) |=>
    (LOWER_VALUE_O == $past(s_q.rate_filt)))
    else $error("Lower display not showing filtered rate.");
  div_len_a: assert property ((s_q.state == ST_TOT) && (s_q.bit_cnt == 7'h00) |->
    ##96 (s_q.state == ST_RATE))
    else $error("Total division did not take 96 cycles.");
  tot_hold_a: assert property ((s_q.state == ST_RATE) || (s_q.state == ST_FILT) |=>
    $stable(TOTAL_O))
    else $error("Total changed during rate work.");
  rate_zero_a: assert property ((s_q.state == ST_RATE) && s_q.stale &&
    (s_q.bit_cnt == 7'(DW - 1)) |=> (s_q.rate_raw == '0) ##1 (RATE_O == '0))
    else $error("Stale rate not forced to zero.");
  override_a: assert property ((s_q.state == ST_FILT) && ovr |=>
    (RATE_O == $past(s_q.rate_raw)))
    else $error("Override did not jump to new rate.");
  bypass_a: assert property ((s_q.state == ST_FILT) && (tau_d == 4'h0) |=>
    (RATE_O == $past(s_q.rate_raw)))
    else $error("Zero time constant did not pass rate.");
  clip_a: assert property (!$stable(cfg_now) |=> CLIP_CLEAR_O)
    else $error("Scaling change did not clear clip-off.");

  ovr_c: cover property ((s_q.state == ST_FILT) && ovr);
  stale_c: cover property (s_q.stale ##1 !s_q.stale);
  lin_c: cover property ((s_q.state == ST_LIN) ##17 (s_q.state == ST_TOT));
  edit_c: cover property (MENU_MODE_I == frt_pkg::MENU_DP_UP ##1 MENU_MODE_I == frt_pkg::MENU_DP_LO);
endmodule : frt_scale
`default_nettype wire

//--- verilog/frt_pkg.sv
// Purpose: Shared constants and decoders for the flow rate and total scaling path.
// Assumes: CORE_CLK_I at 100 MHz; divisors carry four decimal fraction digits.
// Notes: Values leave the path as fixed point with FRAC_BITS fraction bits.
`default_nettype none
package frt_pkg;
  // ----------------------------------------------------------------
  // Clock and widths
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ = 64'd100000000;
  localparam int CNT_W = 32;
  localparam int PER_W = 34;
  localparam int FAC_W = 30;
  localparam int VAL_W = 48;
  localparam int FRAC_BITS = 16;
  localparam int DIV_W = 96;
  localparam int UPD_W = 24;
  localparam int LIN_DEPTH = 16;
  localparam int LIN_DW = PER_W + FAC_W;
  localparam logic [DIV_W-1:0] DEC_SCALE = 96'h5F5E100;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int UPD_MS = 100;
  localparam logic [UPD_W-1:0] UPD_CYC_DEF = UPD_W'(CLK_HZ * UPD_MS / 1000);
  localparam int MIN_FREQ_MHZ = 10;
  localparam logic [PER_W-1:0] ZERO_CYC_DEF = PER_W'(CLK_HZ * 1000 / MIN_FREQ_MHZ);
  // ----------------------------------------------------------------
  // Timebase, filter and display settings
  // ----------------------------------------------------------------
  localparam logic [11:0] TB_SEC = 12'h001;
  localparam logic [11:0] TB_MIN = 12'h03C;
  localparam logic [11:0] TB_HR = 12'hE10;
  localparam logic [1:0] TBSEL_SEC = 2'h0;
  localparam logic [1:0] TBSEL_MIN = 2'h1;
  localparam int unsigned TAU_DS [10] = '{0, 13, 43, 65, 87, 113, 157, 209, 252, 315};
  localparam int unsigned DEV_PCT [10] = '{0, 1, 2, 4, 8, 12, 16, 24, 32, 64};
  localparam logic [16:0] ALPHA_ONE = 17'h10000;
  localparam logic [2:0] UP_DP_MAX = 3'h7;
  localparam logic [2:0] LO_DP_MAX = 3'h5;
  localparam logic [1:0] MENU_RUN = 2'h0;
  localparam logic [1:0] MENU_DP_UP = 2'h1;
  localparam logic [1:0] MENU_DP_LO = 2'h2;
  localparam logic [1:0] MENU_FILT = 2'h3;
  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  function automatic logic [3:0] frt_digit(input logic [3:0] d);
    return (d > 4'h9) ? 4'h9 : d;
  endfunction : frt_digit

  function automatic logic [2:0] frt_dp(input logic [2:0] p, input logic [2:0] mx);
    return (p > mx) ? mx : p;
  endfunction : frt_dp

  function automatic logic [11:0] frt_tb(input logic [1:0] sel);
    return (sel == TBSEL_SEC) ? TB_SEC : (sel == TBSEL_MIN) ? TB_MIN : TB_HR;
  endfunction : frt_tb

  function automatic logic [16:0] frt_alpha(input logic [3:0] d);
    if (TAU_DS[d] == 0)
    begin
      return ALPHA_ONE;
    end
    return 17'((64'h10000 * UPD_MS) / (TAU_DS[d] * 100));
  endfunction : frt_alpha
endpackage : frt_pkg
`default_nettype wire

//--- verilog/frt_lin_mem.sv
// Purpose: Segment table memory with one write port and a registered read port.
// Assumes: One clock; read data appear one edge after the address.
// Notes: Each word holds a period threshold above a meter factor.
`timescale 1ns/1ns
`default_nettype none
module frt_lin_mem #(
  parameter int DEPTH = 16,
  parameter int DW = 64
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Write port
  input wire logic we_i,
  input wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  // Read port
  input wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [DW-1:0] rd;
  } frt_mem_t;

  frt_mem_t m_q;
  frt_mem_t m_d;

  always_comb
  begin
    m_d = m_q;
    m_d.rd = m_q.mem[raddr_i];
    if (we_i)
    begin
      m_d.mem[waddr_i] = wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      m_q <= '0;
    end
    else
    begin
      m_q <= m_d;
    end
  end

  assign rdata_o = m_q.rd;
endmodule : frt_lin_mem
`default_nettype wire

//--- tb/frt_scale_tb.sv
// Purpose: Self-checking bench for the scaling, filter and display path.
// Assumes: UPD_CYC 300 and ZERO_CYC 2000 shorten the update and stale counts.
// Notes: The driver queues expected values; a monitor pops and compares them.
`timescale 1ns/1ns
`default_nettype none
module frt_scale_tb;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  typedef struct {
    int sel;
    logic [63:0] exp;
  } frt_exp_t;
  localparam int UPD = 300;
  localparam int ZCYC = 2000;
  localparam int PER = 100;
  localparam logic [63:0] RAW1 = 64'hF4240 << 16;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic pulse = 1'b0;
  logic tclr = 1'b0;
  logic [29:0] mf = 30'h2710;
  logic [29:0] ts = 30'h2710;
  logic [29:0] rs = 30'h2710;
  logic [1:0] tb = 2'h0;
  logic [7:0] smo = 8'h00;
  logic lin_en = 1'b0;
  logic [4:0] lin_cnt = 5'h01;
  logic lin_we = 1'b0;
  logic [3:0] lin_addr = 4'h0;
  logic [33:0] lin_per = 34'h0;
  logic [29:0] lin_fac = 30'h2710;
  logic up_rate = 1'b1;
  logic [2:0] up_dp = 3'h0;
  logic [2:0] lo_dp = 3'h0;
  logic [1:0] menu = 2'h0;
  logic [47:0] total, rate, up_val, lo_val;
  logic [2:0] up_dp_o, lo_dp_o;
  logic rzero, clip, rann, tann;
  logic run = 1'b0;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int clips = 0;
  int sent = 0;
  int seed = 32'he65b4e9b;
  int gap = 0;
  int burst = 0;
  int i, n, k, c0;
  logic [63:0] tbv [3] = '{64'h1, 64'h3C, 64'hE10};
  frt_exp_t q[$];
  frt_exp_t e;

  frt_scale #(.UPD_CYC(frt_pkg::UPD_W'(UPD)), .ZERO_CYC(frt_pkg::PER_W'(ZCYC))) DUT (
    .CORE_CLK_I(clk), .RSTN_I(rstn), .PULSE_A_I(pulse), .TOTAL_CLR_I(tclr),
    .INPUT_A_PULSE_DIVISOR_I(mf), .TOTAL_SCALE_DIVISOR_I(ts), .RATE_SCALE_DIVISOR_I(rs),
    .RATE_TIMEBASE_SELECT_I(tb), .RATE_SMOOTHING_SETTING_I(smo), .LIN_EN_I(lin_en),
    .LIN_COUNT_I(lin_cnt), .LIN_WE_I(lin_we), .LIN_ADDR_I(lin_addr), .LIN_PERIOD_I(lin_per),
    .LIN_FACTOR_I(lin_fac), .UPPER_SHOWS_RATE_I(up_rate),
    .UPPER_DECIMAL_POINT_POSITION_I(up_dp), .LOWER_DECIMAL_POINT_POSITION_I(lo_dp),
    .MENU_MODE_I(menu), .TOTAL_O(total), .RATE_O(rate), .RATE_ZERO_O(rzero),
    .CLIP_CLEAR_O(clip), .UPPER_VALUE_O(up_val), .LOWER_VALUE_O(lo_val),
    .UPPER_DP_O(up_dp_o), .LOWER_DP_O(lo_dp_o), .RATE_ANN_O(rann), .TOTAL_ANN_O(tann)
  );

  // --------------------------------------------------------------
  // Clock, pulses, counters and monitor
  // --------------------------------------------------------------
  always #5 clk = ~clk;

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (clip === 1'b1)
      clips <= clips + 1;
    if (pulse === 1'b1)
      sent <= sent + 1;
  end

  always @(negedge clk)
  begin
    if (burst != 0)
    begin
      pulse <= 1'b1;
      burst <= burst - 1;
    end
    else if (run)
    begin
      gap <= (gap == PER - 1) ? 0 : gap + 1;
      pulse <= (gap == PER - 1);
    end
    else
      pulse <= 1'b0;
    if (cycles == 40000)
    begin
      errors++;
      wrap_up();
    end
  end

  always @(negedge clk)
  begin
    #2;
    while (q.size() > 0)
    begin
      e = q.pop_front();
      case (e.sel)
        0: check("total", {16'h0, total}, e.exp);
        1: check("rate", {16'h0, rate}, e.exp);
        2: check("upper value", {16'h0, up_val}, e.exp);
        3: check("lower value", {16'h0, lo_val}, e.exp);
        4: check("upper point", {61'h0, up_dp_o}, e.exp);
        5: check("lower point", {61'h0, lo_dp_o}, e.exp);
        6: check("annunciators", {62'h0, rann, tann}, e.exp);
        7: check("rate zero", {63'h0, rzero}, e.exp);
        8: check("clip pulses", {32'h0, 32'(clips)}, e.exp);
        default: check("filter step", {63'h0, rate != 48'h0 && {16'h0, rate} < e.exp}, 64'h1);
      endcase
    end
  end

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic note(input int sel, input logic [63:0] exp);
    q.push_back('{sel, exp});
  endtask : note

  task automatic cyc(input int c);
    repeat (c) @(negedge clk);
  endtask : cyc

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    cyc(2);
    for (i = 0; i < 8; i++)
    begin
      up_dp = 3'($random(seed));
      lo_dp = 3'(i);
      cyc(2);
      note(4, {61'h0, up_dp});
      note(5, {61'h0, (lo_dp > 3'h5) ? 3'h5 : lo_dp});
    end
    tclr = 1'b1;
    cyc(2);
    tclr = 1'b0;
    n = 1 + ($random(seed) & 32'h1F);
    ts = 30'h4E20;
    burst = n;
    cyc(2 * UPD + 300);
    note(0, 64'(n) << 15);
    rs = 30'h4E20;
    tb = 2'h2;
    cyc(2 * UPD);
    note(0, 64'(n) << 15);
    mf = 30'h1388;
    ts = 30'h2710;
    cyc(2 * UPD);
    note(0, 64'(n) << 17);
    for (i = 0; i < 5; i++)
    begin
      c0 = clips;
      case (i)
        0: mf = 30'h2710;
        1: ts = ts ^ 30'h1;
        2: rs = 30'h2710;
        3: tb = 2'h0;
        default: up_dp = up_dp ^ 3'h1;
      endcase
      cyc(4);
      note(8, 64'(c0 + 1));
    end
    ts = 30'h2710;
    run = 1'b1;
    for (i = 0; i < 3; i++)
    begin
      tb = 2'(i);
      cyc(2 * UPD + 300);
      note(1, RAW1 * tbv[i]);
      note(2, RAW1 * tbv[i]);
      note(6, 64'h2);
      note(7, 64'h0);
    end
    run = 1'b0;
    cyc(2 * UPD + 300);
    menu = 2'h1;
    cyc(2);
    note(2, RAW1 * tbv[2]);
    note(3, 64'(sent) << 16);
    note(6, 64'h2);
    menu = 2'h2;
    cyc(2);
    note(2, 64'(sent) << 16);
    note(6, 64'h1);
    note(4, 64'h5);
    menu = 2'h3;
    cyc(2);
    note(3, RAW1 * tbv[2]);
    menu = 2'h0;
    run = 1'b1;
    for (i = 0; i < 2; i++)
    begin
      lin_addr = 4'(i);
      lin_per = (i == 0) ? 34'h3FFFFFFFF : 34'hC8;
      lin_fac = (i == 0) ? 30'h2710 : 30'h4E20;
      lin_we = 1'b1;
      cyc(1);
      lin_we = 1'b0;
      cyc(1);
    end
    lin_cnt = 5'h02;
    lin_en = 1'b1;
    tb = 2'h0;
    cyc(2 * UPD + 300);
    note(1, RAW1 >> 1);
    lin_en = 1'b0;
    run = 1'b0;
    cyc(ZCYC + 2 * UPD + 300);
    note(7, 64'h1);
    note(1, 64'h0);
    smo = 8'h10;
    run = 1'b1;
    k = 0;
    while (rate === 48'h0 && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
    note(9, RAW1);
    smo = 8'h19;
    cyc(2 * UPD + 100);
    note(1, RAW1);
    cyc(4);
    wrap_up();
  end
endmodule : frt_scale_tb
`default_nettype wire
